// ---- hdl/bag_pkg.sv ----
// constants and carrier types for the bus arbiter and sizing glue
package bag_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int          ADDR_W         = 4;
  localparam int          DATA_W         = 32;
  localparam logic [3:0]  OFS_CONFIG     = 4'h0;
  localparam logic [3:0]  OFS_PIN_ASSIGN = 4'h4;
  localparam logic [3:0]  OFS_STATUS     = 4'h8;
  localparam logic [7:0]  CONFIG_RESET   = 8'h00;
  localparam logic [15:0] PIN_RESET      = 16'h0000;

  // ----------------------------------------
  // bus answers and fixed levels
  // ----------------------------------------
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [1:0]  SIZE_IDLE      = 2'h3;
  localparam logic [2:0]  TM_ALL         = 3'h7;
  localparam logic [2:0]  TM_NONE        = 3'h0;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  // reset-time configuration byte, bit 7 down to bit 0
  typedef struct packed {
    logic       auto_ack;
    logic [1:0] boot_port_size;
    logic       pin_mode;
    logic [1:0] clock_range;
    logic [1:0] bus_clock_divide;
  } bag_cfg_t;

  // transfer type and modifier, all in asserted sense
  typedef struct packed {
    logic       transfer_type_bit1;
    logic       transfer_type_bit0;
    logic [2:0] transfer_modifier;
  } bag_xfer_t;

  typedef enum logic [1:0] {
    BAG_OWN_NONE,
    BAG_OWN_CPU,
    BAG_OWN_TGT
  } bag_owner_t;

  typedef struct packed {
    logic [7:0] sampled_data;
    logic [1:0] size_in;
    bag_owner_t owner;
    logic       transfer_ack;
    logic       spare_test;
    logic       int7_ack;
    logic       emulator_dma_ack;
  } bag_status_t;

endpackage

// ---- hdl/bag_size_ack.sv ----
// port-size acknowledge to size and transfer-acknowledge conversion
`timescale 1ns/10ps
module bag_size_ack
  import bag_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       sys_reset_n,
  input  wire logic       target_grant,
  input  wire logic       port_size_ack0,
  input  wire logic       port_size_ack1,
  output logic      [1:0] size_out,
  output logic            size_oe_n,
  output logic            transfer_ack,
  output logic            spare_test
);

  wire logic both_ack = port_size_ack0 & port_size_ack1;
  wire logic any_ack  = port_size_ack0 | port_size_ack1;

  // ----------------------------------------
  // size and acknowledge
  // ----------------------------------------
  // forced high in reset so the processor never sees a glitch
  assign size_out[0]  = !sys_reset_n | (!port_size_ack0 & port_size_ack1); // [RL6] [RL10]
  assign size_out[1]  = !sys_reset_n | (!port_size_ack1 & port_size_ack0); // [RL7] [RL10]
  // size pins are processor inputs while the target is master and during system reset
  assign size_oe_n    = !(target_grant | !sys_reset_n); // [RL12]
  assign transfer_ack = sys_reset_n & target_grant & any_ack; // [RL9] [RL13]
  // reset default announces a 32-bit port
  assign spare_test   = !sys_reset_n | both_ack; // [RL8] [RL11]

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_size_reset: assert property ( // [RL10]
    !sys_reset_n |-> size_out == SIZE_IDLE && !size_oe_n)
    else $error("size pins not held high in reset");
  chk_size_zero: assert property ( // [RL6]
    sys_reset_n && port_size_ack1 && !port_size_ack0 |-> size_out == 2'h1)
    else $error("size bit 0 decode wrong");
  chk_size_one: assert property ( // [RL7]
    sys_reset_n && port_size_ack0 && !port_size_ack1 |-> size_out == 2'h2)
    else $error("size bit 1 decode wrong");
  chk_ta_owner: assert property ( // [RL9]
    transfer_ack |-> target_grant && any_ack && sys_reset_n)
    else $error("transfer ack without target acknowledge");
  chk_ta_given: assert property ( // [RL9]
    sys_reset_n && target_grant && any_ack |-> transfer_ack)
    else $error("transfer ack missing");
  chk_spare_wide: assert property ( // [RL8] [RL11]
    (both_ack || !sys_reset_n) |-> spare_test)
    else $error("spare not showing 32-bit port");

endmodule

// ---- hdl/bag_glue.sv ----
// bus arbiter, cycle decode, sizing glue and reset configuration
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// [RL1] emulator DMA acknowledge when type bit 0 set and bit 1 clear
// [RL2] both type bits and all modifier bits set: normal CPU space access
// [RL3] all type and modifier bits clear: interrupt level 7 acknowledge
// [RL4] grant target when it requests and new processor is not granted
// [RL5] grant new processor on request, or target idle with bus driven
// [RL6] size bit 0 when port ack 0 clear and port ack 1 set
// [RL7] size bit 1 when port ack 1 clear and port ack 0 set
// [RL8] spare test output high when both port acks set (32-bit port)
// [RL9] transfer ack when target owns bus and gives either port ack
// [RL10] size outputs held high during reset to avoid glitches
// [RL11] transfer ack sizing defaults to 32 bits at reset via spare
// [RL12] size pins are inputs to processor while target is master
// [RL13] every decode output inactive during system reset; registered grants clear one clock after it asserts
// [RL14] configuration byte driven on low data byte during reset
// [RL15] pin mode zero gives parallel port; one enables alternate functions
// [RL16] data strobe follows address strobe, write cycles one clock later
// [RL17] function code bit 1 high during level 7 interrupt acknowledge
// [RL18] grants never overlap; current holder keeps bus on contention
module bag_glue
  import bag_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [DATA_W-1:0] rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              sys_reset_n,
  input  wire bag_xfer_t         xfer,
  input  wire logic              new_cpu_request,
  input  wire logic              target_request,
  input  wire logic              bus_driven_flag,
  input  wire logic              write_cycle,
  input  wire logic              address_strobe,
  input  wire logic              port_size_ack0,
  input  wire logic              port_size_ack1,
  input  wire logic [1:0]        size_in,
  input  wire logic [7:0]        data_low_in,
  output logic                   new_cpu_grant,
  output logic                   target_grant,
  output logic                   emulator_dma_ack,
  output logic                   cpu_space_access,
  output logic                   int7_ack,
  output logic                   function_code_one,
  output logic                   delayed_strobe,
  output logic      [1:0]        size_out,
  output logic                   size_oe_n,
  output logic                   transfer_ack,
  output logic                   spare_test,
  output logic      [7:0]        data_low_out,
  output logic                   data_low_oe_n,
  output logic      [15:0]       alt_pin_enable
);

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en);
    merge_byte = en ? new_v : old_v;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  bag_cfg_t    cfg;
  logic [15:0] pin_assign;
  logic        as_q;
  logic        aw_got;
  logic        w_got;
  logic [3:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;

  // ----------------------------------------
  // cycle decode
  // ----------------------------------------
  wire logic tt0 = xfer.transfer_type_bit0;
  wire logic tt1 = xfer.transfer_type_bit1;

  assign emulator_dma_ack  = sys_reset_n & tt0 & !tt1; // [RL1] [RL13]
  assign cpu_space_access  = sys_reset_n & tt0 & tt1
                           & (xfer.transfer_modifier == TM_ALL); // [RL2] [RL13]
  assign int7_ack          = sys_reset_n & !tt0 & !tt1
                           & (xfer.transfer_modifier == TM_NONE); // [RL3] [RL13]
  assign function_code_one = int7_ack; // [RL17]

  // write strobes wait one clock so write data can settle first
  assign delayed_strobe = sys_reset_n & address_strobe
                        & (!write_cycle | as_q); // [RL16] [RL13]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      as_q <= 1'b0;
    end else begin
      as_q <= address_strobe & sys_reset_n;
    end
  end

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  // registered grants; a holder blocks the other side until it lets go,
  // so a handover always shows one idle cycle between grants
  wire logic cpu_wants = new_cpu_request | (!target_request & bus_driven_flag); // [RL5]
  wire logic next_new_cpu_grant = sys_reset_n & cpu_wants & !target_grant; // [RL18] [RL13]
  wire logic next_target_grant  = sys_reset_n & target_request
                                & !new_cpu_grant & !next_new_cpu_grant; // [RL4] [RL18]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      new_cpu_grant <= 1'b0;
      target_grant  <= 1'b0;
    end else begin
      new_cpu_grant <= next_new_cpu_grant;
      target_grant  <= next_target_grant;
    end
  end

  // ----------------------------------------
  // sizing
  // ----------------------------------------
  bag_size_ack u_size (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .sys_reset_n    (sys_reset_n),
    .target_grant   (target_grant),
    .port_size_ack0 (port_size_ack0),
    .port_size_ack1 (port_size_ack1),
    .size_out       (size_out),
    .size_oe_n      (size_oe_n),
    .transfer_ack   (transfer_ack),
    .spare_test     (spare_test)
  );

  // ----------------------------------------
  // reset configuration and pin functions
  // ----------------------------------------
  assign data_low_out   = cfg; // [RL14]
  assign data_low_oe_n  = sys_reset_n; // [RL14]
  // mode zero keeps every pin a parallel port bit
  assign alt_pin_enable = cfg.pin_mode ? pin_assign : 16'h0000; // [RL15]

  // ----------------------------------------
  // register write
  // ----------------------------------------
  // address and data may arrive in either order; answer once both held
  assign awready = !aw_got & !bvalid;
  assign wready  = !w_got & !bvalid;

  wire logic aw_fire = awvalid & awready;
  wire logic w_fire  = wvalid & wready;
  wire logic aw_have = aw_got | aw_fire;
  wire logic w_have  = w_got | w_fire;
  wire logic do_wr   = aw_have & w_have & !bvalid;

  wire logic [3:0]  wr_addr = aw_got ? aw_q : awaddr;
  wire logic [31:0] wr_data = w_got ? w_q : wdata;
  wire logic [3:0]  wr_strb = w_got ? ws_q : wstrb;
  wire logic        wr_cfg  = do_wr & (wr_addr == OFS_CONFIG);
  wire logic        wr_pin  = do_wr & (wr_addr == OFS_PIN_ASSIGN);
  wire logic        wr_ok   = (wr_addr == OFS_CONFIG) | (wr_addr == OFS_PIN_ASSIGN)
                            | (wr_addr == OFS_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_q   <= 4'h0;
      w_q    <= 32'h00000000;
      ws_q   <= 4'h0;
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_q <= awaddr;
      end
      if (w_fire) begin
        w_q  <= wdata;
        ws_q <= wstrb;
      end
      aw_got <= aw_have & !do_wr;
      w_got  <= w_have & !do_wr;
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg        <= CONFIG_RESET;
      pin_assign <= PIN_RESET;
    end else begin
      if (wr_cfg) begin
        cfg <= merge_byte(cfg, wr_data[7:0], wr_strb[0]);
      end
      if (wr_pin) begin
        pin_assign[7:0]  <= merge_byte(pin_assign[7:0], wr_data[7:0], wr_strb[0]);
        pin_assign[15:8] <= merge_byte(pin_assign[15:8], wr_data[15:8], wr_strb[1]);
      end
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  bag_status_t status;
  bag_owner_t  owner;

  assign owner = target_grant  ? BAG_OWN_TGT :
                 new_cpu_grant ? BAG_OWN_CPU : BAG_OWN_NONE;

  assign status = '{sampled_data:     data_low_in,
                    size_in:          size_in,
                    owner:            owner,
                    transfer_ack:     transfer_ack,
                    spare_test:       spare_test,
                    int7_ack:         int7_ack,
                    emulator_dma_ack: emulator_dma_ack};

  assign arready = !rvalid;

  wire logic rd_fire = arvalid & arready;
  wire logic rd_ok   = (araddr == OFS_CONFIG) | (araddr == OFS_PIN_ASSIGN)
                     | (araddr == OFS_STATUS);
  wire logic [31:0] rd_word = (araddr == OFS_CONFIG)     ? {24'h000000, cfg} :
                              (araddr == OFS_PIN_ASSIGN) ? {16'h0000, pin_assign} :
                              (araddr == OFS_STATUS)     ? {16'h0000, status} :
                                                           32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // an attempt started on the last reset edge would judge flops still held
  // in reset, so checking resumes one edge after release
  logic out_of_reset;

  always_ff @(posedge aclk) begin
    out_of_reset <= aresetn;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !out_of_reset);

  sequence s_tgt_release;
    target_grant ##1 !target_grant;
  endsequence

  sequence s_write_open;
    sys_reset_n && write_cycle && address_strobe && !$past(address_strobe);
  endsequence

  sequence s_write_hold;
    (sys_reset_n && write_cycle && address_strobe) [*2];
  endsequence

  chk_dma_decode: assert property ( // [RL1]
    sys_reset_n && tt0 && !tt1 |-> emulator_dma_ack && !int7_ack && !cpu_space_access)
    else $error("emulator access not flagged");
  chk_space_decode: assert property ( // [RL2]
    sys_reset_n && tt0 && tt1 && xfer.transfer_modifier == TM_ALL
      |-> cpu_space_access && !emulator_dma_ack)
    else $error("cpu space access not flagged");
  chk_int7_decode: assert property ( // [RL3] [RL17]
    sys_reset_n && !tt0 && !tt1 && xfer.transfer_modifier == TM_NONE
      |-> int7_ack && function_code_one)
    else $error("level 7 acknowledge missing");
  chk_fc_only_int7: assert property ( // [RL17]
    function_code_one |-> !tt0 && !tt1 && xfer.transfer_modifier == TM_NONE)
    else $error("function code raised outside level 7 ack");
  chk_tgt_grant: assert property ( // [RL4]
    $rose(target_grant) |-> $past(target_request) && !$past(new_cpu_grant))
    else $error("target granted without cause");
  chk_cpu_grant: assert property ( // [RL5]
    sys_reset_n && !target_grant && (new_cpu_request || (!target_request && bus_driven_flag))
      |=> new_cpu_grant)
    else $error("new processor not granted");
  chk_grant_excl: assert property ( // [RL18]
    !(new_cpu_grant && target_grant))
    else $error("both grants active");
  chk_holder_keeps: assert property ( // [RL18]
    target_grant && target_request && new_cpu_request && sys_reset_n |=> target_grant)
    else $error("target lost bus while still requesting");
  chk_handover_gap: assert property ( // [RL18]
    s_tgt_release |-> !new_cpu_grant)
    else $error("no idle cycle at handover");
  chk_reset_quiet: assert property ( // [RL13]
    !sys_reset_n |=> !new_cpu_grant && !target_grant)
    else $error("grant active after system reset");
  chk_decode_quiet: assert property ( // [RL13]
    !sys_reset_n |-> !emulator_dma_ack && !int7_ack && !delayed_strobe && !transfer_ack)
    else $error("decode output active in reset");
  chk_ds_wr_delay: assert property ( // [RL16]
    s_write_open |-> !delayed_strobe ##1 (delayed_strobe || !address_strobe || !sys_reset_n))
    else $error("write strobe not delayed one clock");
  chk_ds_wr_hold: assert property ( // [RL16]
    s_write_hold |-> delayed_strobe)
    else $error("write strobe missing after delay");
  chk_ds_read: assert property ( // [RL16]
    sys_reset_n && address_strobe && !write_cycle |-> delayed_strobe)
    else $error("read strobe not immediate");
  chk_cfg_drive: assert property ( // [RL14]
    !sys_reset_n |-> !data_low_oe_n && data_low_out == cfg)
    else $error("configuration byte not driven in reset");
  chk_pin_mode: assert property ( // [RL15]
    alt_pin_enable != 16'h0000 |-> cfg.pin_mode && (alt_pin_enable & ~pin_assign) == 16'h0000)
    else $error("alternate pin enabled without mode");
  chk_wr_answer: assert property (
    do_wr |=> bvalid)
    else $error("write not answered");

endmodule

// ---- testbench/bag_target_model.sv ----
// far-side model: target bus master, its port-size acks and the shared size pins
`timescale 1ns/10ps
module bag_target_model
(
  input  wire logic       aclk,
  input  wire logic       want_bus,
  input  wire logic [1:0] ack_cmd,
  input  wire logic       slow,
  input  wire logic       target_grant,
  input  wire logic [1:0] size_out,
  input  wire logic       size_oe_n,
  input  wire logic [1:0] cpu_size,
  output logic            target_request,
  output logic            port_size_ack0,
  output logic            port_size_ack1,
  output logic      [1:0] size_in
);
  logic [1:0] ack_d1 = 2'h0;
  logic [1:0] ack_d2 = 2'h0;
  logic [1:0] last   = 2'h0;

  // slow target answers two cycles after being told to
  always_ff @(posedge aclk) begin
    ack_d1 <= ack_cmd;
    ack_d2 <= ack_d1;
    last   <= size_in;
  end

  assign target_request = want_bus;
  assign {port_size_ack1, port_size_ack0} = slow ? ack_d2 : ack_cmd;
  // processor leaves the size pins alone while the target is master; floating pins
  // show the inverse of their last level so a stale value cannot pass
  assign size_in = !size_oe_n ? size_out : (target_grant ? ~last : cpu_size);
endmodule

// ---- testbench/bag_glue_tb.sv ----
// self-checking bench for the bus arbiter and sizing glue
`timescale 1ns/10ps
module bag_glue_tb
  import bag_pkg::*;
;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sys_reset_n;
  logic              awready, wready, bvalid, arready, rvalid, new_cpu_request, target_request;
  logic              bus_driven_flag, write_cycle, address_strobe, port_size_ack0, port_size_ack1;
  logic              new_cpu_grant, target_grant, emulator_dma_ack, cpu_space_access, int7_ack;
  logic              function_code_one, delayed_strobe, size_oe_n, transfer_ack, spare_test;
  logic              data_low_oe_n, want_bus, slow, m_cpu, m_tgt, as_q, mon_on;
  logic [3:0]        awaddr, wstrb, araddr;
  logic [1:0]        bresp, rresp, size_in, size_out, ack_cmd, cpu_size;
  logic [7:0]        data_low_in, data_low_out;
  logic [15:0]       alt_pin_enable;
  logic [DATA_W-1:0] wdata, rdata;
  bag_xfer_t         xfer;
  int                n_fail, n_compared;
  wire               sr = sys_reset_n;
  wire               a0 = port_size_ack0;
  wire               a1 = port_size_ack1;
  wire [4:0]         xb = xfer;
  wire               want_cpu = new_cpu_request | (!target_request & bus_driven_flag);

  bag_glue dut (.*);
  bag_target_model partner (.aclk(aclk), .want_bus(want_bus), .ack_cmd(ack_cmd), .slow(slow),
    .target_grant(target_grant), .size_out(size_out), .size_oe_n(size_oe_n), .cpu_size(cpu_size),
    .target_request(target_request), .port_size_ack0(port_size_ack0),
    .port_size_ack1(port_size_ack1), .size_in(size_in));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ----------------------------------------
  // reference for grants and strobe history
  // ----------------------------------------
  // holder keeps the bus; a release leaves one idle cycle before the other party
  always @(posedge aclk) begin
    as_q  <= aresetn & sr & address_strobe;
    m_cpu <= aresetn & sr & want_cpu & !m_tgt;
    m_tgt <= aresetn & sr & target_request & !m_cpu & (m_tgt | !want_cpu);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [1:0] exp_size(input logic rst_n, input logic k0, input logic k1);
    exp_size = rst_n ? {k0 & !k1, k1 & !k0} : SIZE_IDLE;
  endfunction

  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // bus master tasks
  // ----------------------------------------
  // only the watchdog ends a wait; one edge passes before the next call drives again
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic       ah, wh, bh;
    logic [1:0] r;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid & bready;
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
    check(bh, 1'b1, "write answer");
    check(r, er, "write resp");
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ah, rh;
    logic [31:0] d;
    logic [1:0]  r;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      ah = arvalid & arready;
      rh = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
    check(rh, 1'b1, "read answer");
    check(d, ed, "read data");
    check(r, er, "read resp");
  endtask

  // ----------------------------------------
  // continuous port monitor
  // ----------------------------------------
  always @(negedge aclk) begin
    if (aresetn && mon_on) begin
      check(emulator_dma_ack, sr & xb[3] & !xb[4], "dma ack");
      check(cpu_space_access, sr & (xb == 5'h1F), "cpu space");
      check(int7_ack, sr & (xb == 5'h00), "int7 ack");
      check(function_code_one, sr & (xb == 5'h00), "fc one");
      check(target_grant, m_tgt, "target grant");
      check(new_cpu_grant, m_cpu, "cpu grant");
      check(target_grant & new_cpu_grant, 1'b0, "grant overlap");
      check(spare_test, sr ? a0 & a1 : 1'b1, "spare");
      check(transfer_ack, sr & m_tgt & (a0 | a1), "transfer ack");
      check(size_oe_n, sr & !m_tgt, "size enable");
      check(size_out, exp_size(sr, a0, a1), "size");
      if (m_tgt) check(size_in, exp_size(sr, a0, a1), "size pins");
      check(delayed_strobe, sr & address_strobe & (!write_cycle | as_q), "strobe");
      check(data_low_oe_n, sr, "cfg drive");
    end
  end

  initial begin
    #250000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int          seed;
    logic [31:0] r;
    seed = 1178;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, wstrb, araddr, wdata} = '0;
    {new_cpu_request, bus_driven_flag, write_cycle, address_strobe, xfer, data_low_in} = '0;
    {want_bus, slow, ack_cmd, cpu_size, mon_on, n_fail, n_compared} = '0;
    sys_reset_n = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    mon_on <= 1'b1;
    @(posedge aclk);
    axi_rd(OFS_CONFIG, {24'h0, CONFIG_RESET}, RESP_OKAY);
    axi_rd(OFS_PIN_ASSIGN, {16'h0, PIN_RESET}, RESP_OKAY);
    axi_wr(OFS_PIN_ASSIGN, 32'h0000A5C3, 4'h3, RESP_OKAY);
    axi_wr(OFS_CONFIG, 32'h000000EB, 4'h1, RESP_OKAY);
    check(alt_pin_enable, 16'h0000, "alt off");
    axi_wr(OFS_CONFIG, 32'h000000FF, 4'hE, RESP_OKAY);
    axi_rd(OFS_CONFIG, 32'h000000EB, RESP_OKAY);
    axi_wr(OFS_CONFIG, 32'h0000005A, 4'h1, RESP_OKAY);
    check(alt_pin_enable, 16'hA5C3, "alt on");
    // status is read only: a write is answered and leaves it alone
    data_low_in <= 8'h3C;
    cpu_size    <= 2'h2;
    axi_wr(OFS_STATUS, 32'h0000FFFF, 4'hF, RESP_OKAY);
    axi_rd(OFS_STATUS, 32'h00003C82, RESP_OKAY);
    axi_wr(4'hC, 32'h00000001, 4'hF, RESP_SLVERR);
    axi_rd(4'hC, 32'h0, RESP_SLVERR);
    sys_reset_n <= 1'b0;
    @(negedge aclk);
    check(data_low_out, 8'h5A, "cfg byte");
    @(posedge aclk);
    sys_reset_n <= 1'b1;
    $display("test registers done");
    want_bus <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    check(target_grant, 1'b1, "walk grant");
    @(posedge aclk);
    ack_cmd <= 2'h1;
    @(negedge aclk);
    check(transfer_ack, 1'b1, "walk ack");
    @(posedge aclk);
    want_bus <= 1'b0;
    new_cpu_request <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    check(new_cpu_grant | target_grant, 1'b0, "idle gap");
    @(posedge aclk);
    @(negedge aclk);
    check(new_cpu_grant, 1'b1, "walk cpu");
    @(posedge aclk);
    new_cpu_request <= 1'b0;
    ack_cmd <= 2'h0;
    $display("test arbitration done");
    for (int i = 0; i < 32; i++) begin
      xfer <= bag_xfer_t'(i[4:0]);
      @(posedge aclk);
    end
    $display("test decode codes done");
    for (int i = 0; i < 700; i++) begin
      r = $random(seed);
      xfer <= bag_xfer_t'(r[4:0]);
      new_cpu_request <= r[5] & r[6];
      bus_driven_flag <= r[7];
      write_cycle <= r[8];
      address_strobe <= r[9];
      want_bus <= r[10] | r[11];
      ack_cmd <= r[13:12];
      slow <= r[14];
      cpu_size <= r[16:15];
      data_low_in <= r[24:17];
      sys_reset_n <= (r[29:26] != 4'h0);
      aresetn <= !(i >= 350 && i < 352);
      @(posedge aclk);
    end
    $display("test random done");
    summarize();
  end
endmodule
